// *** hdl/ccs_pixel_buffer.sv ***
/*
 * Shift-register FIFO for pixel words; head entry and valid are flops.
 * Assumes writer and reader share mclk.
 */
`timescale 1ns/10ps
`default_nettype none
module ccs_pixel_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2,
    localparam int LW   = $clog2(DEPTH + 1)
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset_n,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    output logic      [WIDTH-1:0] outData,
    input  wire logic             outReady,
    // occupancy
    output logic      [LW-1:0]    level
);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [LW-1:0]    count_q;
    logic [LW-1:0]    count_d;
    logic             valid_q;
    logic             push;
    logic             pop;

    assign inReady  = (count_q < LW'(DEPTH));
    assign push     = inValid && inReady;
    assign pop      = outReady && valid_q;
    assign outValid = valid_q;
    assign outData  = mem_q[0];
    assign level    = count_q;

    always_comb begin
        count_d = count_q + LW'(push) - LW'(pop);
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= '0;
            valid_q <= 1'b0;
        end else begin
            count_q <= count_d;
            valid_q <= (count_d != '0);
        end
    end

    // entries slide toward the head on a pop; the write lands after them
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            if (pop) begin
                for (int i = 0; i < DEPTH - 1; i++) begin
                    mem_q[i] <= mem_q[i+1];
                end
            end
            if (push) begin
                mem_q[int'(count_q) - int'(pop)] <= inData;
            end
        end
    end

endmodule : ccs_pixel_buffer
`default_nettype wire

// *** hdl/ccs_pkg.sv ***
/*
 * Shared constants, timing counts and carrier types for the CCD readout
 * sequencer. Assumes a single 25 MHz system clock; each timed-state count is
 * derived from a time in nanoseconds and that clock rate.
 */
package ccs_pkg;

    // ************************************************************
    // array geometry
    // ************************************************************
    localparam int VERT_ROWS   = 1024;
    localparam int VERT_COLS   = 1024;
    localparam int HORIZ_PIX   = 1032;
    localparam int ACTIVE_COLS = 1008;
    localparam int ACTIVE_ROWS = 1018;
    localparam int DARK_COLS   = 16;
    localparam int DARK_ROWS   = 6;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int CLK_MHZ       = 25;
    localparam int PIX_MAX_MHZ   = 20;
    localparam int T_PD_XFER_NS  = 1000;
    localparam int T_VERT_NS     = 400;
    localparam int T_HMOVE_NS    = 200;
    localparam int T_SHUTTER_NS  = 2000;
    localparam int PIX_PHASES    = 5;
    localparam int ADC_LAT       = 4;
    localparam int BUF_DEPTH     = 2;
    localparam int PIX_W         = 12;

    // least times round up, never below one cycle
    function automatic int ns_to_cyc(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction : ns_to_cyc

    localparam int PIX_MIN_CYC  = (CLK_MHZ + PIX_MAX_MHZ - 1) / PIX_MAX_MHZ;
    localparam int PD_XFER_CYC  = ns_to_cyc(T_PD_XFER_NS);
    localparam int VERT_CYC     = ns_to_cyc(T_VERT_NS);
    localparam int HMOVE_CYC    = ns_to_cyc(T_HMOVE_NS);
    localparam int SHUTTER_CYC  = ns_to_cyc(T_SHUTTER_NS);

    // ************************************************************
    // carriers
    // ************************************************************
    typedef struct packed {
        logic vertPhaseOneClock;
        logic vertTransferLevel;
        logic vertPhaseTwoClock;
        logic firstRowHorizPhaseOne;
        logic secondRowHorizPhaseOne;
        logic sharedHorizPhaseTwo;
        logic lineDumpGate;
        logic resetClock;
        logic shutterPulseLevel;
        logic adcStrobe;
    } ccs_pins_t;

    // rest levels: both phase-one horizontal clocks high, phase two low
    localparam ccs_pins_t PINS_IDLE = '{vertPhaseOneClock: 1'b1,
                                       firstRowHorizPhaseOne: 1'b1,
                                       secondRowHorizPhaseOne: 1'b1,
                                       default: 1'b0};

    typedef struct packed {
        logic        dualMode;
        logic        binTwo;
        logic        shutterEn;
        logic [10:0] shutterGroup;
        logic [10:0] dumpRows;
    } ccs_cfg_t;

    typedef struct packed {
        logic [PIX_W-1:0] chanA;
        logic [PIX_W-1:0] chanB;
        logic             dual;
        logic             lineEnd;
    } ccs_pix_t;

    typedef enum logic [3:0] {
        ST_IDLE, ST_PD, ST_RETRACE, ST_SHUT, ST_VHI, ST_VLO,
        ST_ABMOVE, ST_ABREST, ST_SHIFT, ST_END
    } ccs_state_t;

endpackage : ccs_pkg

// *** hdl/ccs_readout_sequencer.sv ***
/*
 * Timing generator that clocks an interline CCD through a whole frame:
 * photodiode transfer, line transfers, optional dual-register readout,
 * binning, line dumps, shutter placement and pixel capture from two ADCs.
 * Assumes external clock drivers translate the pin levels and two ADCs
 * that present data shortly after adcStrobe rises.
 */
`timescale 1ns/10ps
`default_nettype none
module ccs_readout_sequencer #(
    parameter int ROWS   = ccs_pkg::VERT_ROWS,
    parameter int PIXELS = ccs_pkg::HORIZ_PIX
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset_n,
    // frame control
    input  wire logic             frameStart,
    input  wire ccs_pkg::ccs_cfg_t cfg,
    output logic                  busy,
    output logic                  frameDone,
    // sensor clock pins
    output ccs_pkg::ccs_pins_t    pins,
    // adc data pins
    input  wire logic [ccs_pkg::PIX_W-1:0] adcDataA,
    input  wire logic [ccs_pkg::PIX_W-1:0] adcDataB,
    // pixel stream
    output logic                  pixValid,
    output ccs_pkg::ccs_pix_t     pixWord,
    input  wire logic             pixReady
);

    localparam int LW = $clog2(ccs_pkg::BUF_DEPTH + 1);

    // ************************************************************
    // state
    // ************************************************************
    ccs_pkg::ccs_state_t state_q, state_d;
    ccs_pkg::ccs_cfg_t   cfg_q;
    ccs_pkg::ccs_pins_t  pins_q, pins_d;
    logic [7:0]          tCnt_q, tCnt_d;
    logic [10:0]         rowsLeft_q, dumpLeft_q, group_q, pixCnt_q;
    logic [2:0]          phase_q;
    logic                binPass_q, halfDone_q, busy_q, frameDone_q;
    logic                timerDone, lastRow, dumping, pixLast, room, inflight;
    logic [LW-1:0]       bufLevel;
    logic                bufInReady, bufPush;
    ccs_pkg::ccs_pix_t   bufWord;
    logic [ccs_pkg::ADC_LAT-1:0] capDly_q, endDly_q;
    logic [ccs_pkg::PIX_W-1:0]   adcA_s1_q, adcA_s2_q, adcB_s1_q, adcB_s2_q;

    // one timer count per timed state
    function automatic logic [7:0] timerLoad(input ccs_pkg::ccs_state_t s);
        case (s)
            ccs_pkg::ST_PD:                    return 8'(ccs_pkg::PD_XFER_CYC - 1);
            ccs_pkg::ST_SHUT:                  return 8'(ccs_pkg::SHUTTER_CYC - 1);
            ccs_pkg::ST_VHI, ccs_pkg::ST_VLO:  return 8'(ccs_pkg::VERT_CYC - 1);
            ccs_pkg::ST_ABMOVE, ccs_pkg::ST_ABREST:
                                               return 8'(ccs_pkg::HMOVE_CYC - 1);
            default:                           return 8'h00;
        endcase
    endfunction : timerLoad

    assign timerDone = (tCnt_q == 8'h00);
    assign lastRow   = (rowsLeft_q == 11'h001);
    assign dumping   = (dumpLeft_q != 11'h000);
    assign pixLast   = (pixCnt_q == 11'(PIXELS - 1));
    assign inflight  = |capDly_q;
    // in-flight sample needs its own slot, so count it as taken
    assign room      = (int'(bufLevel) + int'(inflight)) < ccs_pkg::BUF_DEPTH;

    // ************************************************************
    // sequencing
    // ************************************************************
    always_comb begin
        state_d = state_q;
        case (state_q)
            ccs_pkg::ST_IDLE: if (frameStart) state_d = ccs_pkg::ST_PD;
            ccs_pkg::ST_PD: if (timerDone) state_d = ccs_pkg::ST_RETRACE;
            ccs_pkg::ST_RETRACE: begin
                if (cfg_q.shutterEn && group_q == cfg_q.shutterGroup) begin
                    state_d = ccs_pkg::ST_SHUT;
                end else begin
                    state_d = ccs_pkg::ST_VHI;
                end
            end
            ccs_pkg::ST_SHUT: if (timerDone) state_d = ccs_pkg::ST_VHI;
            ccs_pkg::ST_VHI: if (timerDone) state_d = ccs_pkg::ST_VLO;
            ccs_pkg::ST_VLO: begin
                if (timerDone) begin
                    if (dumping) begin
                        state_d = lastRow ? ccs_pkg::ST_END : ccs_pkg::ST_VHI;
                    end else if (cfg_q.binTwo && !binPass_q && !lastRow) begin
                        state_d = ccs_pkg::ST_VHI;
                    end else if (cfg_q.dualMode && !halfDone_q && !lastRow) begin
                        state_d = ccs_pkg::ST_ABMOVE;
                    end else begin
                        state_d = ccs_pkg::ST_SHIFT;
                    end
                end
            end
            ccs_pkg::ST_ABMOVE: if (timerDone) state_d = ccs_pkg::ST_ABREST;
            ccs_pkg::ST_ABREST: if (timerDone) state_d = ccs_pkg::ST_VHI;
            ccs_pkg::ST_SHIFT: begin
                if (phase_q == 3'(ccs_pkg::PIX_PHASES - 1) && pixLast) begin
                    state_d = (rowsLeft_q == 11'h000) ? ccs_pkg::ST_END
                                                      : ccs_pkg::ST_RETRACE;
                end
            end
            ccs_pkg::ST_END: state_d = ccs_pkg::ST_IDLE;
            default: state_d = ccs_pkg::ST_IDLE;
        endcase
    end

    always_comb begin
        if (state_d != state_q) begin
            tCnt_d = timerLoad(state_d);
        end else if (!timerDone) begin
            tCnt_d = tCnt_q - 8'h01;
        end else begin
            tCnt_d = tCnt_q;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ccs_pkg::ST_IDLE;
            tCnt_q  <= 8'h00;
        end else begin
            state_q <= state_d;
            tCnt_q  <= tCnt_d;
        end
    end

    // ************************************************************
    // row, group and pass bookkeeping
    // ************************************************************
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_q      <= '0;
            rowsLeft_q <= 11'h000;
            dumpLeft_q <= 11'h000;
            group_q    <= 11'h000;
            binPass_q  <= 1'b0;
            halfDone_q <= 1'b0;
        end else begin
            if (state_q == ccs_pkg::ST_IDLE && frameStart) begin
                cfg_q      <= cfg;
                rowsLeft_q <= 11'(ROWS);
                dumpLeft_q <= cfg.dumpRows;
                group_q    <= 11'h000;
            end
            if (state_q == ccs_pkg::ST_RETRACE) begin
                binPass_q  <= 1'b0;
                halfDone_q <= 1'b0;
            end
            if (state_q == ccs_pkg::ST_VLO && timerDone) begin
                rowsLeft_q <= rowsLeft_q - 11'h001;
                if (dumping) begin
                    dumpLeft_q <= dumpLeft_q - 11'h001;
                end else begin
                    binPass_q <= 1'b1;
                end
            end
            if (state_q == ccs_pkg::ST_ABREST && timerDone) begin
                halfDone_q <= 1'b1;
                binPass_q  <= 1'b0;
            end
            if (state_q == ccs_pkg::ST_SHIFT && state_d != ccs_pkg::ST_SHIFT) begin
                group_q <= group_q + 11'h001;
            end
        end
    end

    // ************************************************************
    // pixel phases
    // ************************************************************
    // five cycles per pixel keeps the rate at 5 MHz, under PIX_MAX_MHZ
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            phase_q  <= 3'h0;
            pixCnt_q <= 11'h000;
        end else if (state_q != ccs_pkg::ST_SHIFT) begin
            phase_q  <= 3'h0;
            pixCnt_q <= 11'h000;
        end else if (phase_q == 3'h0) begin
            if (room) begin
                phase_q <= 3'h1;
            end
        end else if (phase_q == 3'(ccs_pkg::PIX_PHASES - 1)) begin
            phase_q  <= 3'h0;
            pixCnt_q <= pixCnt_q + 11'h001;
        end else begin
            phase_q <= phase_q + 3'h1;
        end
    end

    // ************************************************************
    // pin levels
    // ************************************************************
    always_comb begin
        pins_d = ccs_pkg::PINS_IDLE;
        case (state_q)
            ccs_pkg::ST_PD: begin
                pins_d.vertTransferLevel = 1'b1;
            end
            ccs_pkg::ST_SHUT: begin
                pins_d.shutterPulseLevel = 1'b1;
            end
            ccs_pkg::ST_VHI: begin
                pins_d.vertPhaseOneClock = 1'b0;
                pins_d.vertPhaseTwoClock = 1'b1;
                pins_d.lineDumpGate      = dumping;
            end
            ccs_pkg::ST_VLO: begin
                pins_d.lineDumpGate = dumping;
            end
            ccs_pkg::ST_ABMOVE: begin
                pins_d.firstRowHorizPhaseOne = 1'b0;
            end
            ccs_pkg::ST_SHIFT: begin
                // vertical clocks keep rest levels throughout the line
                if (phase_q == 3'h1) begin
                    pins_d.firstRowHorizPhaseOne  = 1'b0;
                    pins_d.secondRowHorizPhaseOne = !cfg_q.dualMode;
                    pins_d.sharedHorizPhaseTwo    = 1'b1;
                end
                pins_d.adcStrobe  = (phase_q == 3'h3);
                pins_d.resetClock = (phase_q == 3'h4);
            end
            default: begin
                pins_d = ccs_pkg::PINS_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pins_q      <= ccs_pkg::PINS_IDLE;
            busy_q      <= 1'b0;
            frameDone_q <= 1'b0;
        end else begin
            pins_q      <= pins_d;
            busy_q      <= (state_d != ccs_pkg::ST_IDLE);
            frameDone_q <= (state_q == ccs_pkg::ST_END);
        end
    end

    // ************************************************************
    // adc capture
    // ************************************************************
    // pins come from another domain; the first stage feeds only the second
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            adcA_s1_q <= '0;
            adcA_s2_q <= '0;
            adcB_s1_q <= '0;
            adcB_s2_q <= '0;
        end else begin
            adcA_s1_q <= adcDataA;
            adcA_s2_q <= adcA_s1_q;
            adcB_s1_q <= adcDataB;
            adcB_s2_q <= adcB_s1_q;
        end
    end

    // strobe request to synced data is ADC_LAT cycles
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            capDly_q <= '0;
            endDly_q <= '0;
        end else begin
            capDly_q <= {capDly_q[ccs_pkg::ADC_LAT-2:0],
                         (state_q == ccs_pkg::ST_SHIFT && phase_q == 3'h3)};
            endDly_q <= {endDly_q[ccs_pkg::ADC_LAT-2:0], pixLast};
        end
    end

    always_comb begin
        bufWord.chanA   = adcA_s2_q;
        bufWord.chanB   = cfg_q.dualMode ? adcB_s2_q : '0;
        bufWord.dual    = cfg_q.dualMode;
        bufWord.lineEnd = endDly_q[ccs_pkg::ADC_LAT-1];
    end

    // room was checked before the pixel began, so the push is never refused
    assign bufPush = capDly_q[ccs_pkg::ADC_LAT-1] && bufInReady;

    ccs_pixel_buffer #(
        .WIDTH ($bits(ccs_pkg::ccs_pix_t)),
        .DEPTH (ccs_pkg::BUF_DEPTH)
    ) u_buf (
        .mclk     (mclk),
        .reset_n  (reset_n),
        .inValid  (bufPush),
        .inReady  (bufInReady),
        .inData   (bufWord),
        .outValid (pixValid),
        .outData  (pixWord),
        .outReady (pixReady),
        .level    (bufLevel)
    );

    assign pins      = pins_q;
    assign busy      = busy_q;
    assign frameDone = frameDone_q;

endmodule : ccs_readout_sequencer
`default_nettype wire

// *** tb/ccs_readout_sequencer_sva.sv ***
/* Pin-timing assertions for the readout sequencer.
   Sees only the top module's ports; bound at the foot of this file. */
`timescale 1ns/10ps
`default_nettype none
module ccs_readout_sequencer_sva #(
    parameter int ROWS   = 4,
    parameter int PIXELS = 6
) (
    // clock and reset
    input wire logic                      mclk,
    input wire logic                      reset_n,
    // frame control and stream
    input wire logic                      frameStart,
    input wire ccs_pkg::ccs_cfg_t         cfg,
    input wire logic                      busy,
    input wire logic                      frameDone,
    input wire logic                      pixValid,
    input wire ccs_pkg::ccs_pix_t         pixWord,
    input wire logic                      pixReady,
    // sensor and adc pins
    input wire ccs_pkg::ccs_pins_t        pins,
    input wire logic [ccs_pkg::PIX_W-1:0] adcDataA,
    input wire logic [ccs_pkg::PIX_W-1:0] adcDataB
);
    wire logic v1 = pins.vertPhaseOneClock;
    wire logic v2 = pins.vertPhaseTwoClock;
    wire logic vt = pins.vertTransferLevel;
    wire logic ha = pins.firstRowHorizPhaseOne;
    wire logic hb = pins.secondRowHorizPhaseOne;
    wire logic h2 = pins.sharedHorizPhaseTwo;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // ************************************************************
    // properties
    // ************************************************************
    property p_vert_comp; v2 |-> !v1; endproperty
    a_vert_comp: assert property (p_vert_comp) else $error("vertical phases overlap");
    property p_horiz_comp; h2 |-> !ha; endproperty
    a_horiz_comp: assert property (p_horiz_comp) else $error("horizontal phases overlap");
    property p_xfer; $rose(vt) |-> ##24 (vt && v1) ##1 !vt; endproperty
    a_xfer: assert property (p_xfer) else $error("transfer level width wrong");
    property p_v2_pulse; $rose(v2) |-> (v2 && ha)[*5] ##1 (v2 && ha)[*5] ##1 !v2; endproperty
    a_v2_pulse: assert property (p_v2_pulse) else $error("line transfer pulse wrong");
    property p_ab_move; $fell(ha) && !h2 |-> (!ha && hb && !v2)[*5] ##1 ha; endproperty
    a_ab_move: assert property (p_ab_move) else $error("register move wrong");
    property p_pix_seq; $rose(h2) |=> !h2 ##1 pins.adcStrobe ##1 (pins.resetClock && !h2);
    endproperty
    a_pix_seq: assert property (p_pix_seq) else $error("pixel phases wrong");
    property p_shut; pins.shutterPulseLevel |-> !h2 && !pins.adcStrobe && !v2; endproperty
    a_shut: assert property (p_shut) else $error("shutter outside retrace");
    property p_vstatic; h2 |-> v1 && !v2 && !vt; endproperty
    a_vstatic: assert property (p_vstatic) else $error("vertical clock moved in shift");
    property p_dump; pins.lineDumpGate |-> !h2 && !pins.adcStrobe; endproperty
    a_dump: assert property (p_dump) else $error("dump gate outside transfer");
    property p_hold; pixValid && !pixReady |=> pixValid && $stable(pixWord); endproperty
    a_hold: assert property (p_hold) else $error("stalled word changed");
    property p_done; frameDone |=> !busy && !frameDone; endproperty
    a_done: assert property (p_done) else $error("busy after frame end");
    c_move: cover property ($fell(ha) && !h2);
    c_stall: cover property (pixValid && !pixReady);
    c_shut: cover property ($rose(pins.shutterPulseLevel));
endmodule : ccs_readout_sequencer_sva
bind ccs_readout_sequencer ccs_readout_sequencer_sva #(.ROWS(ROWS), .PIXELS(PIXELS)) u_sva (
    .mclk, .reset_n, .frameStart, .cfg, .busy, .frameDone, .pixValid, .pixWord,
    .pixReady, .pins, .adcDataA, .adcDataB);
`default_nettype wire

// *** tb/ccs_readout_sequencer_tb.sv ***
/* Self-checking bench: frames in each mode against a queue model.
   Assumes the sensor model and a 4 row, 6 pixel geometry. */
`timescale 1ns/10ps
`default_nettype none
module ccs_readout_sequencer_tb;
    localparam int ROWS = 4;
    localparam int PIX  = 6;
    logic                      mclk = 1'b0;
    logic                      reset_n = 1'b0;
    logic                      frameStart = 1'b0;
    logic                      pixReady = 1'b0;
    ccs_pkg::ccs_cfg_t         cfg = '0;
    logic                      busy, frameDone, pixValid;
    ccs_pkg::ccs_pins_t        pins;
    ccs_pkg::ccs_pix_t         pixWord;
    logic [ccs_pkg::PIX_W-1:0] adcDataA, adcDataB;
    ccs_pkg::ccs_pix_t         expQ[$];
    int                        nMismatch = 0;
    int                        numChecks = 0;
    always #20 mclk = ~mclk;
    ccs_readout_sequencer #(.ROWS(ROWS), .PIXELS(PIX)) dut (.mclk(mclk), .reset_n(reset_n),
        .frameStart(frameStart), .cfg(cfg), .busy(busy), .frameDone(frameDone), .pins(pins),
        .adcDataA(adcDataA), .adcDataB(adcDataB), .pixValid(pixValid), .pixWord(pixWord),
        .pixReady(pixReady));
    ccs_sensor_model model (.mclk(mclk), .reset_n(reset_n), .pins(pins),
        .adcDataA(adcDataA), .adcDataB(adcDataB));
    task automatic check(input logic ok, input string msg);
        numChecks++;
        if (ok !== 1'b1) begin
            nMismatch++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : check
    task automatic wrapUp();
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrapUp
    // ************************************************************
    // stream monitor; random stalls hold pixReady low about one cycle in four
    // ************************************************************
    always @(negedge mclk) begin
        pixReady = ($urandom % 4) != 0;
        if (reset_n === 1'b1 && pixValid === 1'b1 && pixReady) begin
            if (expQ.size() == 0) check(1'b0, "unexpected word");
            else check(pixWord === expQ.pop_front(), "word differs");
        end
    end
    task automatic frame(input ccs_pkg::ccs_cfg_t c);
        int                rows[$];
        int                lines[$];
        int                a, b, k;
        ccs_pkg::ccs_pix_t w;
        for (int r = c.dumpRows + 1; r <= ROWS; r++) rows.push_back(r);
        while (rows.size() > 0) begin
            a = rows.pop_front();
            if (c.binTwo && rows.size() > 0) a = rows.pop_front();
            lines.push_back(a);
        end
        while (lines.size() > 0) begin
            b = 0;
            a = lines.pop_front();
            if (c.dualMode && lines.size() > 0) begin
                b = a;
                a = lines.pop_front();
            end
            for (k = 1; k <= PIX; k++) begin
                w.chanA = 12'(a * 64 + k);
                w.chanB = (b > 0) ? 12'(2048 + (b % 32) * 64 + k) : 12'h000;
                w.dual = (b > 0);
                w.lineEnd = (k == PIX);
                expQ.push_back(w);
            end
        end
        @(negedge mclk);
        cfg = c;
        frameStart = 1'b1;
        @(negedge mclk);
        frameStart = 1'b0;
        check(busy === 1'b1, "busy not raised");
        k = 0;
        while (frameDone !== 1'b1 && k < 5000) begin
            @(negedge mclk);
            k++;
            // a start while busy must leave no trace
            frameStart = (k == 40);
        end
        frameStart = 1'b0;
        check(k < 5000, "frame never ended");
        @(negedge mclk);
        check(busy === 1'b0, "busy after frame end");
        k = 0;
        while (expQ.size() > 0 && k < 200) begin
            @(negedge mclk);
            k++;
        end
        check(expQ.size() == 0, "words missing");
    endtask : frame
    initial begin
        ccs_pkg::ccs_cfg_t c;
        void'($urandom(32'h7b73));
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        for (int i = 0; i < 4; i++) begin
            c = '0;
            c.dualMode = (i == 1 || i == 2);
            c.binTwo = (i >= 2);
            c.shutterEn = 1'b1;
            c.shutterGroup = 11'($urandom % 3);
            c.dumpRows = (i == 3) ? 11'h002 : 11'h000;
            frame(c);
        end
        wrapUp();
    end
    initial begin
        repeat (30000) @(posedge mclk);
        nMismatch++;
        wrapUp();
    end
endmodule : ccs_readout_sequencer_tb
`default_nettype wire

// *** tb/ccs_sensor_model.sv ***
/* Behavioural sensor with two output channels and their converters.
   Assumes registered pins on mclk; the value shown is row and column. */
`timescale 1ns/10ps
`default_nettype none
module ccs_sensor_model (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 reset_n,
    // sensor pins
    input  wire ccs_pkg::ccs_pins_t   pins,
    // converted outputs
    output logic [ccs_pkg::PIX_W-1:0] adcDataA,
    output logic [ccs_pkg::PIX_W-1:0] adcDataB
);
    // scaled geometry: dark rows and columns are just more rows and columns
    ccs_pkg::ccs_pins_t last_q;
    logic [5:0]         row_q, lineA_q, lineB_q, col_q;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            last_q   <= ccs_pkg::PINS_IDLE;
            row_q    <= 6'h00;
            lineA_q  <= 6'h00;
            lineB_q  <= 6'h00;
            col_q    <= 6'h00;
            adcDataA <= 12'h000;
            adcDataB <= 12'h000;
        end else begin
            last_q <= pins;
            // one progressive scan per transfer pulse
            if (last_q.vertTransferLevel && !pins.vertTransferLevel)
                row_q <= 6'h00;
            // summed pair keeps the later row; dumped rows still advance
            if (last_q.vertPhaseTwoClock && !pins.vertPhaseTwoClock) begin
                row_q   <= row_q + 6'h01;
                lineA_q <= row_q + 6'h01;
                col_q   <= 6'h00;
            end
            // first line moves on to the second register
            if (last_q.firstRowHorizPhaseOne && !pins.firstRowHorizPhaseOne
                && !pins.sharedHorizPhaseTwo)
                lineB_q <= lineA_q;
            // both registers dump together on phase-two fall
            if (last_q.sharedHorizPhaseTwo && !pins.sharedHorizPhaseTwo) begin
                col_q    <= col_q + 6'h01;
                adcDataA <= {lineA_q, col_q + 6'h01};
                adcDataB <= {1'b1, lineB_q[4:0], col_q + 6'h01};
            end
        end
    end
endmodule : ccs_sensor_model
`default_nettype wire
